// [design/adc_regs_defines.svh]
// How it works
// [R01] frame bit 15: 0 read, 1 write
// [R02] frame bits 14-9 carry register index
// [R03] bit 8 reserved, reads zero
// [R04] config bit 7 read-only self-diagnosis flag
// [R05] config bit 6 enables burst mode
// [R06] config bit 5 enables channel sequencer
// [R07] config bits 4-2 oversampling, 2^n samples
// [R08] config bit 1 appends status word
// [R09] config bit 0 same as bit 1
// [R10] select bits 7-4 choose converter B input
// [R11] converter B code 1011b returns 0x5555
// [R12] select bits 3-0 choose converter A input
// [R13] converter A code 1011b returns 0xAAAA
// [R14] range codes: 00/11 10V, 01 2.5V, 10 5V
// [R15] low range register holds channels 3..0
// [R16] every range field resets to 11b
// [R17] config register resets to 0x400
// [R18] select register resets to 0x600
// [R19] high range register holds channels 7..4
// [R20] status word: last channel ids, 8-bit crc
// [R21] writes to read-only bits are ignored
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH

// register indices; byte address is four times the index
`define REG_IDX_CONFIG 6'h02
`define REG_IDX_SELECT 6'h03
`define REG_IDX_RANGE_LO 6'h04
`define REG_IDX_RANGE_HI 6'h05

// frame and register word layout
`define FRAME_DIR_BIT 15
`define FRAME_IDX_HI 14
`define FRAME_IDX_LO 9
`define RESERVED_BIT 8
`define CFG_DIAG_BIT 7
`define CFG_BURST_BIT 6
`define CFG_SEQ_BIT 5
`define CFG_OVS_HI 4
`define CFG_OVS_LO 2
`define CFG_STATUS_BIT 1
`define CFG_CRC_BIT 0

// reset values
`define CFG_RESET 16'h0400
`define SELECT_RESET 16'h0600
`define RANGE_LO_RESET 16'h08ff
`define RANGE_HI_RESET 16'h0aff

// converter input codes and fixed test patterns
`define SEL_FIXED_CODE 4'hb
`define PATTERN_A 16'haaaa
`define PATTERN_B 16'h5555

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [design/adc_regs_pkg.sv]
`include "adc_regs_defines.svh"

package adc_regs_pkg;

  // analog input range per channel
  typedef enum logic [1:0] {
    RANGE_PM10V = 2'h0,
    RANGE_PM2V5 = 2'h1,
    RANGE_PM5V = 2'h2
  } range_t;

  typedef enum logic {
    DIR_READ = 1'b0,
    DIR_WRITE = 1'b1
  } access_dir_t;

  // only the four registers of this bank answer
  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == `REG_IDX_CONFIG) || (idx == `REG_IDX_SELECT) ||
                (idx == `REG_IDX_RANGE_LO) || (idx == `REG_IDX_RANGE_HI);
  endfunction

  // code 11b folds onto the 10 V range as well
  function automatic range_t decode_range(input logic [1:0] code);
    unique case (code)
      2'h1: decode_range = RANGE_PM2V5;
      2'h2: decode_range = RANGE_PM5V;
      default: decode_range = RANGE_PM10V;
    endcase
  endfunction

endpackage

// [design/reg_access_if.sv]
`timescale 1ns/1ns
`default_nettype none

// one register access port into the bank
interface reg_access_if;
  logic wr_en;
  logic [5:0] wr_index;
  logic [7:0] wdata;
  logic wr_hit;
  logic stall;
  logic [5:0] rd_index;
  logic [15:0] rdata;
  logic rd_hit;

  modport master (
    output wr_en, wr_index, wdata, rd_index,
    input wr_hit, stall, rdata, rd_hit
  );
  modport bank (
    input wr_en, wr_index, wdata, rd_index,
    output wr_hit, stall, rdata, rd_hit
  );
endinterface

`default_nettype wire

// [design/frame_port.sv]
`timescale 1ns/1ns
`default_nettype none

module frame_port
  import adc_regs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // host frame
  input wire logic frame_valid,
  input wire logic [15:0] frame_word,
  output logic frame_reply_valid,
  output logic [15:0] frame_reply,
  // bank access
  reg_access_if.master acc
);

  access_dir_t dir;

  // split the frame into direction, index and data
  always_comb
  begin
    dir = access_dir_t'(frame_word[`FRAME_DIR_BIT]); // [R01]
    acc.rd_index = frame_word[`FRAME_IDX_HI:`FRAME_IDX_LO]; // [R02]
    acc.wr_index = frame_word[`FRAME_IDX_HI:`FRAME_IDX_LO]; // [R02]
    acc.wdata = frame_word[7:0]; // reserved bit 8 dropped [R03]
    acc.wr_en = frame_valid && (dir == DIR_WRITE); // [R01]
  end

  // read answer one cycle after the frame; unmapped reads return zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frame_reply_valid <= 1'b0;
      frame_reply <= 16'h0000;
    end
    else
    begin
      frame_reply_valid <= frame_valid && (dir == DIR_READ); // [R01]
      if (frame_valid && (dir == DIR_READ))
        frame_reply <= acc.rd_hit ? acc.rdata : 16'h0000;
    end
  end

endmodule

`default_nettype wire

// [design/axil_slave.sv]
`timescale 1ns/1ns
`default_nettype none

module axil_slave (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bank access
  reg_access_if.master acc
);

  logic aw_full_reg;
  logic w_full_reg;
  logic aw_ok_reg;
  logic [5:0] aw_index_reg;
  logic [7:0] wdata_reg;
  logic lane0_reg;
  logic aw_full_next;
  logic w_full_next;
  logic commit;
  logic ar_take;

  // write commits once both halves are held, the response slot is free and the bank does not stall
  assign commit = aw_full_reg && w_full_reg && !s_axi_bvalid && !acc.stall;
  assign aw_full_next = commit ? 1'b0 : (aw_full_reg || (s_axi_awvalid && s_axi_awready));
  assign w_full_next = commit ? 1'b0 : (w_full_reg || (s_axi_wvalid && s_axi_wready));
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // only byte lane 0 holds writable bits
  assign acc.wr_en = commit && aw_ok_reg && lane0_reg && acc.wr_hit;
  assign acc.wr_index = aw_index_reg;
  assign acc.wdata = wdata_reg;
  assign acc.rd_index = s_axi_araddr[7:2];

  // address and data captured independently, in either order
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_ok_reg <= 1'b0;
      aw_index_reg <= 6'h00;
      wdata_reg <= 8'h00;
      lane0_reg <= 1'b0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_axi_awready <= !aw_full_next;
      s_axi_wready <= !w_full_next;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_index_reg <= s_axi_awaddr[7:2];
        aw_ok_reg <= (s_axi_awaddr[1:0] == 2'h0);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg <= s_axi_wdata[7:0];
        lane0_reg <= s_axi_wstrb[0];
      end
    end
  end

  // write response; misaligned or unmapped answers slave error
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (commit)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_ok_reg && acc.wr_hit) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // single outstanding read, data one cycle after the address
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (acc.rd_hit && (s_axi_araddr[1:0] == 2'h0))
      begin
        s_axi_rdata <= {16'h0000, acc.rdata};
        s_axi_rresp <= `RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

endmodule

`default_nettype wire

// [design/adc_config_regs.sv]
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

module adc_config_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host register frames
  input wire logic frame_valid,
  input wire logic [15:0] frame_word,
  output logic frame_reply_valid,
  output logic [15:0] frame_reply,
  // self-diagnosis result from the power-up check
  input wire logic self_diag_fail_in,
  // converter results
  input wire logic conv_valid,
  input wire logic [15:0] conv_sample_a,
  input wire logic [15:0] conv_sample_b,
  input wire logic [7:0] conv_crc,
  output logic result_valid,
  output logic [15:0] result_a,
  output logic [15:0] result_b,
  output logic status_valid,
  output logic [15:0] status_word,
  // configuration to the converter core
  output logic self_diag_fail_flag,
  output logic burst_mode_enable,
  output logic sequencer_enable,
  output logic [2:0] oversample_ratio_code,
  output logic [7:0] oversample_samples,
  output logic status_append_enable,
  output logic checksum_append_enable,
  output logic [3:0] converter_a_input_select,
  output logic [3:0] converter_b_input_select,
  output adc_regs_pkg::range_t [7:0] group_a_range
);

  import adc_regs_pkg::*;

  localparam logic [15:0] CFG_RST = `CFG_RESET;
  localparam logic [15:0] SEL_RST = `SELECT_RESET;
  localparam logic [15:0] RLO_RST = `RANGE_LO_RESET;
  localparam logic [15:0] RHI_RST = `RANGE_HI_RESET;

  reg_access_if axi_acc ();
  reg_access_if frame_acc ();

  logic [7:0] range_lo_reg;
  logic [7:0] range_hi_reg;
  logic w_en;
  logic [5:0] w_index;
  logic [7:0] w_data;
  logic [7:0] cfg_image;
  logic [7:0] sel_image;

  // assemble a 16-bit register word: zero dir bit, own index, zero reserved bit
  function automatic logic [15:0] read_word(
    input logic [5:0] idx,
    input logic [7:0] cfg,
    input logic [7:0] sel,
    input logic [7:0] rlo,
    input logic [7:0] rhi
  );
    logic [7:0] body;
    body = 8'h00;
    unique case (idx)
      `REG_IDX_CONFIG: body = cfg;
      `REG_IDX_SELECT: body = sel;
      `REG_IDX_RANGE_LO: body = rlo;
      `REG_IDX_RANGE_HI: body = rhi;
      default: body = 8'h00;
    endcase
    read_word = is_mapped(idx) ? {1'b0, idx, 1'b0, body} : 16'h0000; // [R03]
  endfunction

  // fixed code replaces the sample with the converter's test pattern
  function automatic logic [15:0] pick_result(
    input logic [3:0] sel,
    input logic [15:0] sample,
    input logic [15:0] pattern
  );
    pick_result = (sel == `SEL_FIXED_CODE) ? pattern : sample;
  endfunction

  // 2^n samples per result, one when oversampling is off
  function automatic logic [7:0] samples_for(input logic [2:0] code);
    samples_for = 8'(8'h01 << code); // [R07]
  endfunction

  // bus slave and frame port share the register bank
  axil_slave u_axil (
    .clk(clk),
    .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .acc(axi_acc.master)
  );

  frame_port u_frame (
    .clk(clk),
    .reset_n(reset_n),
    .frame_valid(frame_valid),
    .frame_word(frame_word),
    .frame_reply_valid(frame_reply_valid),
    .frame_reply(frame_reply),
    .acc(frame_acc.master)
  );

  // live images of the writable bytes for read-back
  assign cfg_image = {self_diag_fail_flag, burst_mode_enable, sequencer_enable,
                      oversample_ratio_code, status_append_enable, checksum_append_enable};
  assign sel_image = {converter_b_input_select, converter_a_input_select};

  // read ports and hit flags; a frame write holds off a bus write for a cycle
  always_comb
  begin
    axi_acc.rdata = read_word(axi_acc.rd_index, cfg_image, sel_image,
                              range_lo_reg, range_hi_reg);
    axi_acc.rd_hit = is_mapped(axi_acc.rd_index);
    axi_acc.wr_hit = is_mapped(axi_acc.wr_index);
    axi_acc.stall = frame_acc.wr_en;
    frame_acc.rdata = read_word(frame_acc.rd_index, cfg_image, sel_image,
                                range_lo_reg, range_hi_reg);
    frame_acc.rd_hit = is_mapped(frame_acc.rd_index);
    frame_acc.wr_hit = is_mapped(frame_acc.wr_index);
    frame_acc.stall = 1'b0;
  end

  // one write per cycle, frame first
  always_comb
  begin
    w_en = frame_acc.wr_en || axi_acc.wr_en;
    w_index = frame_acc.wr_en ? frame_acc.wr_index : axi_acc.wr_index; // [R02]
    w_data = frame_acc.wr_en ? frame_acc.wdata : axi_acc.wdata;
  end

  // configuration fields; bit 7 is never written
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      burst_mode_enable <= CFG_RST[`CFG_BURST_BIT]; // [R17]
      sequencer_enable <= CFG_RST[`CFG_SEQ_BIT]; // [R17]
      oversample_ratio_code <= CFG_RST[`CFG_OVS_HI:`CFG_OVS_LO]; // [R17]
      status_append_enable <= CFG_RST[`CFG_STATUS_BIT]; // [R17]
      checksum_append_enable <= CFG_RST[`CFG_CRC_BIT]; // [R17]
    end
    else if (w_en && (w_index == `REG_IDX_CONFIG))
    begin
      burst_mode_enable <= w_data[`CFG_BURST_BIT]; // [R05]
      sequencer_enable <= w_data[`CFG_SEQ_BIT]; // [R06]
      oversample_ratio_code <= w_data[`CFG_OVS_HI:`CFG_OVS_LO]; // [R07]
      status_append_enable <= w_data[`CFG_STATUS_BIT]; // [R08]
      checksum_append_enable <= w_data[`CFG_CRC_BIT]; // [R09] [R21]
    end
  end

  // sticky failure flag; only a reset clears it, so a later glitch cannot hide it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      self_diag_fail_flag <= CFG_RST[`CFG_DIAG_BIT];
    else if (self_diag_fail_in)
      self_diag_fail_flag <= 1'b1; // [R04] [R21]
  end

  // oversample count follows the code, one cycle behind
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      oversample_samples <= 8'h01;
    else
      oversample_samples <= samples_for(oversample_ratio_code); // [R07]
  end

  // converter input selection
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      converter_a_input_select <= SEL_RST[3:0]; // [R18]
      converter_b_input_select <= SEL_RST[7:4]; // [R18]
    end
    else if (w_en && (w_index == `REG_IDX_SELECT))
    begin
      converter_a_input_select <= w_data[3:0]; // [R12]
      converter_b_input_select <= w_data[7:4]; // [R10]
    end
  end

  // group-a range codes, four 2-bit fields per register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      range_lo_reg <= RLO_RST[7:0]; // [R16]
      range_hi_reg <= RHI_RST[7:0]; // [R16]
    end
    else if (w_en && (w_index == `REG_IDX_RANGE_LO))
      range_lo_reg <= w_data; // [R15]
    else if (w_en && (w_index == `REG_IDX_RANGE_HI))
      range_hi_reg <= w_data; // [R19]
  end

  // decoded ranges lag the register by one cycle to keep outputs registered
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      group_a_range <= '{default: RANGE_PM10V}; // [R16]
    else
      for (int ch = 0; ch < 4; ch++)
      begin
        group_a_range[ch] <= decode_range(range_lo_reg[2*ch +: 2]); // [R14] [R15]
        group_a_range[ch+4] <= decode_range(range_hi_reg[2*ch +: 2]); // [R14] [R19]
      end
  end

  // conversion results with fixed-pattern override
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      result_valid <= 1'b0;
      result_a <= 16'h0000;
      result_b <= 16'h0000;
    end
    else
    begin
      result_valid <= conv_valid;
      if (conv_valid)
      begin
        result_a <= pick_result(converter_a_input_select, conv_sample_a, `PATTERN_A); // [R13]
        result_b <= pick_result(converter_b_input_select, conv_sample_b, `PATTERN_B); // [R11]
      end
    end
  end

  // status word follows every result while either append bit is set
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_valid <= 1'b0;
      status_word <= 16'h0000;
    end
    else
    begin
      status_valid <= conv_valid && (status_append_enable || checksum_append_enable); // [R08] [R09]
      if (conv_valid)
        status_word <= {converter_a_input_select, converter_b_input_select, conv_crc}; // [R20]
    end
  end

endmodule

`default_nettype wire

// [verif/adc_regs_assertions.sv]
`timescale 1ns/1ns
`default_nettype none

module adc_regs_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched inputs
  input wire logic frame_valid,
  input wire logic [15:0] frame_word,
  input wire logic self_diag_fail_in,
  input wire logic conv_valid,
  input wire logic [7:0] conv_crc,
  // watched outputs
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic frame_reply_valid,
  input wire logic [15:0] frame_reply,
  input wire logic self_diag_fail_flag,
  input wire logic [2:0] oversample_ratio_code,
  input wire logic [7:0] oversample_samples,
  input wire logic status_append_enable,
  input wire logic checksum_append_enable,
  input wire logic [3:0] converter_a_input_select,
  input wire logic [3:0] converter_b_input_select,
  input wire logic result_valid,
  input wire logic [15:0] result_a,
  input wire logic [15:0] result_b,
  input wire logic status_valid,
  input wire logic [15:0] status_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // a conversion taken, and one with the status word requested
  sequence conv_taken;
    conv_valid;
  endsequence
  sequence conv_with_status;
    conv_taken ##0 (status_append_enable || checksum_append_enable);
  endsequence
  sequence read_frame;
    frame_valid && !frame_word[15];
  endsequence

  chk_diag_latch: assert property (self_diag_fail_in |=> self_diag_fail_flag)
    else $error("diag flag missed a failure");
  chk_diag_sticky: assert property (self_diag_fail_flag |=> self_diag_fail_flag)
    else $error("diag flag cleared without reset");
  chk_reserved_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[8] && !s_axi_rdata[15])
    else $error("reserved read bit set");
  chk_frame_reply: assert property (read_frame |=> frame_reply_valid && !frame_reply[8])
    else $error("read frame got no clean reply");
  chk_ovs_samples: assert property (1'b1 |=> oversample_samples == (8'h01 << $past(oversample_ratio_code)))
    else $error("oversample count wrong");
  chk_fixed_a: assert property (conv_taken ##0 converter_a_input_select == 4'hb |=> result_valid && result_a == 16'haaaa)
    else $error("converter a pattern wrong");
  chk_fixed_b: assert property (conv_taken ##0 converter_b_input_select == 4'hb |=> result_valid && result_b == 16'h5555)
    else $error("converter b pattern wrong");
  chk_status_gate: assert property (conv_taken |=> status_valid == $past(status_append_enable || checksum_append_enable))
    else $error("status append gating wrong");
  chk_status_word: assert property (conv_with_status |=> status_word == {$past(converter_a_input_select), $past(converter_b_input_select), $past(conv_crc)})
    else $error("status word content wrong");
endmodule

`default_nettype wire

// [verif/frame_host.sv]
`timescale 1ns/1ns
`default_nettype none

module frame_host (
  // clock
  input wire logic clk,
  // frame lines
  output logic frame_valid,
  output logic [15:0] frame_word,
  input wire logic frame_reply_valid,
  input wire logic [15:0] frame_reply
);
  // idle frame lines
  initial
  begin
    frame_valid = 1'b0;
    frame_word = 16'h0000;
  end

  // one frame; idle word shows the inverse so a stale copy is never mistaken
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d,
    output logic [15:0] r, output logic ok);
    logic [15:0] w;
    w = {wr, idx, 1'b1, d}; // bit 8 set to prove it is ignored
    @(posedge clk);
    frame_valid <= 1'b1;
    frame_word <= w;
    @(posedge clk);
    frame_valid <= 1'b0;
    frame_word <= ~w;
    @(posedge clk);
    r = frame_reply;
    ok = frame_reply_valid;
  endtask
endmodule

`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import adc_regs_pkg::*;
  logic clk, reset_n, self_diag_fail_in, conv_valid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, conv_crc, oversample_samples;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, converter_a_input_select, converter_b_input_select;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic frame_valid, frame_reply_valid, result_valid, status_valid, self_diag_fail_flag;
  logic [15:0] frame_word, frame_reply, conv_sample_a, conv_sample_b;
  logic [15:0] result_a, result_b, status_word;
  logic burst_mode_enable, sequencer_enable, status_append_enable, checksum_append_enable;
  logic [2:0] oversample_ratio_code;
  range_t [7:0] group_a_range;
  int miscompares = 0;
  int samples_checked = 0;
  logic [15:0] w;
  logic [1:0] r;
  logic ok, sv;

  adc_config_regs adc_config_regs_inst (.*);
  frame_host frame_host_inst (.clk(clk), .frame_valid(frame_valid), .frame_word(frame_word),
    .frame_reply_valid(frame_reply_valid), .frame_reply(frame_reply));

  // 50 MHz clock
  always #10 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [7:0] ad(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, wd;
    aw = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    while (!(aw && wd))
    begin
      @(posedge clk);
      if (!aw && s_axi_awready)
      begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // read one word and judge data and response together
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, re}, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'b0;
  endtask

  task automatic conv(input logic [15:0] a, input logic [15:0] b, input logic [7:0] c);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_sample_a <= a;
    conv_sample_b <= b;
    conv_crc <= c;
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
    sv = status_valid;
    chk("result_valid", 1, result_valid);
  endtask

  task automatic t_reset;
    rd_chk(ad(`REG_IDX_CONFIG), 32'h0000_0400, 2'h0);
    rd_chk(ad(`REG_IDX_SELECT), 32'h0000_0600, 2'h0);
    rd_chk(ad(`REG_IDX_RANGE_LO), 32'h0000_08ff, 2'h0);
    rd_chk(ad(`REG_IDX_RANGE_HI), 32'h0000_0aff, 2'h0);
    rd_chk(8'h18, 32'h0000_0000, 2'h2);
    $display("test reset done");
  endtask

  task automatic t_config;
    axi_wr(ad(`REG_IDX_CONFIG), 32'hffff_ffff, 4'hf);
    rd_chk(ad(`REG_IDX_CONFIG), 32'h0000_047f, 2'h0);
    chk("burst", 1, burst_mode_enable);
    chk("seq", 1, sequencer_enable);
    chk("status_en", 1, status_append_enable);
    chk("crc_en", 1, checksum_append_enable);
    chk("ovs", 7, oversample_ratio_code);
    for (int n = 0; n < 8; n++)
    begin
      frame_host_inst.xfer(1'b1, `REG_IDX_CONFIG, 8'(n << 2), w, ok);
      repeat (2) @(posedge clk);
      chk("samples", 32'h1 << n, oversample_samples);
      chk("burst", 0, burst_mode_enable);
    end
    $display("test config done");
  endtask

  task automatic t_select;
    frame_host_inst.xfer(1'b1, `REG_IDX_CONFIG, 8'h01, w, ok);
    frame_host_inst.xfer(1'b1, `REG_IDX_SELECT, 8'hbb, w, ok);
    conv(16'h1234, 16'h4321, 8'h5a);
    chk("result_a", 16'haaaa, result_a);
    chk("result_b", 16'h5555, result_b);
    chk("status_valid", 1, sv);
    chk("status_word", 16'hbb5a, status_word);
    frame_host_inst.xfer(1'b1, `REG_IDX_SELECT, 8'h98, w, ok);
    frame_host_inst.xfer(1'b0, `REG_IDX_SELECT, 8'h00, w, ok);
    chk("reply_valid", 1, ok);
    chk("reply", 16'h0698, w);
    frame_host_inst.xfer(1'b1, `REG_IDX_CONFIG, 8'h02, w, ok);
    conv(16'h1234, 16'h4321, 8'ha5);
    chk("result_a", 16'h1234, result_a);
    chk("result_b", 16'h4321, result_b);
    chk("status_word", 16'h89a5, status_word);
    frame_host_inst.xfer(1'b1, `REG_IDX_CONFIG, 8'h00, w, ok);
    conv(16'h0001, 16'h0002, 8'h00);
    chk("status_valid", 0, sv);
    $display("test select done");
  endtask

  task automatic t_range;
    logic [15:0] codes;
    codes = 16'he41b;
    axi_wr(ad(`REG_IDX_RANGE_LO), 32'h0000_001b, 4'h1);
    axi_wr(ad(`REG_IDX_RANGE_HI), 32'h0000_00e4, 4'h1);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++)
      chk("range", codes[2*i+:2] == 2'h1 ? RANGE_PM2V5 : codes[2*i+:2] == 2'h2 ? RANGE_PM5V :
        RANGE_PM10V, group_a_range[i]);
    $display("test range done");
  endtask

  task automatic t_refuse;
    axi_wr(ad(`REG_IDX_CONFIG), 32'h0000_0060, 4'h0);
    chk("bresp", 0, r);
    rd_chk(ad(`REG_IDX_CONFIG), 32'h0000_0400, 2'h0);
    axi_wr(8'h09, 32'h0000_0060, 4'h1);
    chk("bresp", 2, r);
    frame_host_inst.xfer(1'b0, 6'h06, 8'h00, w, ok);
    chk("unmapped", 0, w);
    self_diag_fail_in <= 1'b1;
    @(posedge clk);
    self_diag_fail_in <= 1'b0;
    axi_wr(ad(`REG_IDX_CONFIG), 32'h0000_0000, 4'h1);
    rd_chk(ad(`REG_IDX_CONFIG), 32'h0000_0480, 2'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd_chk(ad(`REG_IDX_CONFIG), 32'h0000_0400, 2'h0);
    rd_chk(ad(`REG_IDX_SELECT), 32'h0000_0600, 2'h0);
    $display("test refuse done");
  endtask

  // stimulus; all inputs idle at time zero
  initial
  begin
    {clk, reset_n, self_diag_fail_in, conv_valid, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, conv_crc, conv_sample_a, conv_sample_b} = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_config();
    t_select();
    t_range();
    t_refuse();
    wrap_up();
  end

  // whole run is well under a thousand cycles; five thousand means a hang
  initial
  begin
    #100000;
    miscompares++;
    $display("BAD watchdog expected done seen hang");
    wrap_up();
  end
endmodule

bind adc_config_regs adc_regs_assertions adc_regs_assertions_inst (.*);

`default_nettype wire
